/* inc/rfft_pkg.sv */
// Shared constants and types of the streaming radix-4 transform unit.
// Assumes a single clock domain and a synchronous, active-low reset.

// =====================================================================
// Package
package rfft_pkg;
    localparam int  RFFT_DATA_W     = 16;
    localparam int  RFFT_TW_W       = 16;
    localparam int  RFFT_TW_FRAC    = 14;
    localparam int  RFFT_RADIX_LOG  = 2;
    localparam int  RFFT_N_MIN      = 16;
    localparam int  RFFT_N_MAX      = 1024;
    localparam int  RFFT_N_DEFAULT  = 64;
    localparam int  RFFT_MEM_SINGLE = 1;
    localparam int  RFFT_MEM_TRIPLE = 3;
    localparam int  RFFT_FIFO_DEPTH = 4;
    localparam int  RFFT_TAG_W      = 2;
    localparam int  RFFT_SMAX       = 2 ** (RFFT_DATA_W - 1) - 1;
    localparam int  RFFT_SMIN       = -(2 ** (RFFT_DATA_W - 1));
    localparam real RFFT_PI         = 3.14159265358979;
    localparam logic RFFT_DIR_FWD   = 1'b0;
    localparam logic RFFT_DIR_INV   = 1'b1;

    typedef logic signed [RFFT_DATA_W-1:0] rfft_smp_t;
    typedef logic signed [RFFT_DATA_W+1:0] rfft_wide_t;
    typedef logic signed [2*RFFT_DATA_W:0] rfft_prod_t;

    typedef enum logic [2:0] {
        st_idle,
        st_rd,
        st_calc,
        st_wr,
        st_out
    } rfft_state_e;
endpackage

/* rtl/rfft_fifo.sv */
// Small valid/ready FIFO used between the transform memory and the output register.
// Assumes one clock and a synchronous active-low reset; depth is a power of two.

module rfft_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_rst_n,
    // Fill side
    input  wire logic             i_wr_valid,
    output logic                  o_wr_ready,
    input  wire logic [WIDTH-1:0] i_wr_data,
    // Drain side
    output logic                  o_rd_valid,
    input  wire logic             i_rd_ready,
    output logic [WIDTH-1:0]      o_rd_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("FIFO depth must be a power of two of at least two");
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wp_reg;
    logic [AW-1:0]    rp_reg;
    logic [AW:0]      cnt_reg;
    logic             push;
    logic             pop;

    assign o_wr_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign o_rd_valid = (cnt_reg != '0);
    assign o_rd_data  = mem_reg[rp_reg];
    assign push       = i_wr_valid && o_wr_ready;
    assign pop        = o_rd_valid && i_rd_ready;

    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem_reg[wp_reg] <= i_wr_data;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wp_reg <= wp_reg + 1'b1;
            end
            if (pop) begin
                rp_reg <= rp_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* rtl/rfft_stream.sv */
// Streaming radix-4 transform unit: frames of N complex samples in, N bins out.
// Assumes a synchronous source honouring o_ready and a consumer with a ready input.
//
// What this block does
// RULE_01: Transform is built from radix-4 four-point butterflies over log4(N) stages.
// RULE_02: Forward bin k is sum of x(m) times exp(-2 pi i m k / N).
// RULE_03: Input stream is cut into back-to-back frames of exactly N samples.
// RULE_04: Source gives real and imaginary parts on two separate input ports.
// RULE_05: Each bin leaves as real and imaginary words on two separate outputs.
// RULE_06: Direction input low selects forward, high selects inverse transform.
// RULE_07: Frame-start output is high on the first bin of each frame only.
// RULE_08: Ready output is high exactly when another input sample can be taken.
// RULE_09: Length N is a build parameter: 16, 64, 256 or 1024.
// RULE_10: One, two or three frame memories; the 16-point size allows one only.
// RULE_11: Build option scales all bins by 1/N or by 1/(2N).
// RULE_12: With invalidate enabled an overflowed transform is not delivered as data.
// RULE_13: Source supplies sixteen-bit real and imaginary components.
// RULE_14: Samples offered while ready is low are discarded.
// RULE_15: After start-up the first valid sample opens a new input frame.
// RULE_16: Reset returns to the idle state at once and drops output in progress.
// RULE_17: After reset no output is valid until a whole frame was processed.
// RULE_18: At most one sample in and one bin out per clock.
// RULE_19: Overflow output is high on the bins of a frame that overflowed.

module rfft_stream
    import rfft_pkg::*;
#(
    parameter int N_POINTS   = RFFT_N_DEFAULT,
    parameter int MEM_MODE   = RFFT_MEM_SINGLE,
    parameter bit HALF_SCALE = 1'b0,
    parameter bit INVALIDATE = 1'b0
) (
    // Clock and reset
    input  wire logic                   i_mclk,
    input  wire logic                   i_rst_n,
    // Sample input
    input  wire logic                   i_in_valid,
    input  wire logic [RFFT_DATA_W-1:0] i_in_real,
    input  wire logic [RFFT_DATA_W-1:0] i_in_imag,
    input  wire logic                   i_inverse,
    output logic                        o_ready,
    // Bin output
    output logic                        o_valid,
    input  wire logic                   i_out_ready,
    output logic [RFFT_DATA_W-1:0]      o_bin_real,
    output logic [RFFT_DATA_W-1:0]      o_bin_imag,
    output logic                        o_frame_start,
    output logic                        o_ovf
);
    localparam int LOGN   = $clog2(N_POINTS);
    localparam int NST    = LOGN / RFFT_RADIX_LOG;
    localparam int BW     = (MEM_MODE > 1) ? $clog2(MEM_MODE) : 1;
    localparam int CW     = $clog2(MEM_MODE + 1);
    localparam int FIFO_W = 2 * RFFT_DATA_W + RFFT_TAG_W;
    localparam logic [LOGN-1:0] LAST_IDX = LOGN'(N_POINTS - 1);

    // =====================================================================
    // Build checks
    if (N_POINTS < RFFT_N_MIN || N_POINTS > RFFT_N_MAX || (N_POINTS & (N_POINTS - 1)) != 0
        || (LOGN % RFFT_RADIX_LOG) != 0) begin : g_chk_n // RULE_09
        $error("Transform length must be 16, 64, 256 or 1024");
    end
    if (MEM_MODE < RFFT_MEM_SINGLE || MEM_MODE > RFFT_MEM_TRIPLE
        || (N_POINTS == RFFT_N_MIN && MEM_MODE != RFFT_MEM_SINGLE)) begin : g_chk_mem // RULE_10
        $error("Memory mode must be 1, 2 or 3, and 1 for the smallest length");
    end
    if (RFFT_DATA_W != 16) begin : g_chk_w // RULE_13
        $error("Sample components must be sixteen bits wide");
    end

    // =====================================================================
    // Twiddle tables, computed at elaboration
    typedef rfft_smp_t tw_arr_t [N_POINTS];

    function automatic tw_arr_t mk_tw(input bit is_sin);
        tw_arr_t t;
        real     ph;
        real     v;
        for (int e = 0; e < N_POINTS; e++) begin
            ph = 2.0 * RFFT_PI * e / N_POINTS;
            v  = (is_sin ? $sin(ph) : $cos(ph)) * (2.0 ** RFFT_TW_FRAC);
            t[e] = RFFT_TW_W'($rtoi(v + ((v >= 0.0) ? 0.5 : -0.5)));
        end
        return t;
    endfunction

    localparam tw_arr_t TW_COS = mk_tw(1'b0);
    localparam tw_arr_t TW_SIN = mk_tw(1'b1);

    // Bins come out of the in-place decimation-in-frequency memory in base-4 reversed order.
    function automatic logic [LOGN-1:0] digit_rev(input logic [LOGN-1:0] v);
        logic [LOGN-1:0] r;
        r = '0;
        for (int d = 0; d < NST; d++) begin
            r[RFFT_RADIX_LOG*d +: RFFT_RADIX_LOG] = v[LOGN-RFFT_RADIX_LOG-RFFT_RADIX_LOG*d +: RFFT_RADIX_LOG];
        end
        return r;
    endfunction

    function automatic logic [RFFT_DATA_W:0] sat(input rfft_prod_t v);
        if (v > rfft_prod_t'(RFFT_SMAX)) begin
            sat = {1'b1, RFFT_DATA_W'(RFFT_SMAX)};
        end else if (v < rfft_prod_t'(RFFT_SMIN)) begin
            sat = {1'b1, RFFT_DATA_W'(RFFT_SMIN)};
        end else begin
            sat = {1'b0, v[RFFT_DATA_W-1:0]};
        end
    endfunction

    // =====================================================================
    // State
    rfft_smp_t         mem_re [MEM_MODE][N_POINTS];
    rfft_smp_t         mem_im [MEM_MODE][N_POINTS];
    logic              inv_bank_reg [MEM_MODE];
    rfft_state_e       state_reg;
    logic [LOGN-1:0]   in_cnt_reg;
    logic [LOGN-1:0]   out_cnt_reg;
    logic [LOGN-1:0]   out_idx_reg;
    logic [BW-1:0]     ld_b_reg;
    logic [BW-1:0]     pr_b_reg;
    logic [CW-1:0]     busy_reg;
    logic [CW-1:0]     busy_next;
    logic [2:0]        stage_reg;
    logic [LOGN-3:0]   bf_reg;
    logic [1:0]        k_reg;
    logic              ovf_reg;
    rfft_smp_t         a_re [4];
    rfft_smp_t         a_im [4];
    rfft_smp_t         y_re [4];
    rfft_smp_t         y_im [4];
    rfft_smp_t         u_re [4];
    rfft_smp_t         u_im [4];
    logic [LOGN-1:0]   addr;
    logic [LOGN-1:0]   tw_e;
    rfft_smp_t         rot_re;
    rfft_smp_t         rot_im;
    logic              rot_ovf;
    logic              accept;
    logic              load_done;
    logic              out_adv;
    logic              unload_done;
    logic              proc_inv;
    logic              drop_frame;
    logic              fifo_wr_ready;
    logic              fifo_rd_valid;
    logic              fifo_rd_ready;
    logic [FIFO_W-1:0] fifo_rd_data;

    assign accept      = i_in_valid && o_ready; // RULE_14
    assign load_done   = accept && (in_cnt_reg == LAST_IDX); // RULE_03
    assign proc_inv    = inv_bank_reg[pr_b_reg];
    assign drop_frame  = INVALIDATE && ovf_reg; // RULE_12
    assign out_adv     = (state_reg == st_out) && (drop_frame || fifo_wr_ready);
    assign unload_done = out_adv && (out_cnt_reg == LAST_IDX);
    assign busy_next   = busy_reg + CW'(load_done) - CW'(unload_done);

    // =====================================================================
    // Input framing and bank bookkeeping
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin // RULE_16
            in_cnt_reg <= '0;
            ld_b_reg   <= '0;
            pr_b_reg   <= '0;
            busy_reg   <= '0;
            o_ready    <= 1'b0;
        end else begin
            if (accept) begin // RULE_15
                in_cnt_reg <= (in_cnt_reg == LAST_IDX) ? '0 : in_cnt_reg + 1'b1; // RULE_03
            end
            if (load_done) begin
                ld_b_reg <= (ld_b_reg == BW'(MEM_MODE - 1)) ? '0 : ld_b_reg + 1'b1; // RULE_10
            end
            if (unload_done) begin
                pr_b_reg <= (pr_b_reg == BW'(MEM_MODE - 1)) ? '0 : pr_b_reg + 1'b1;
            end
            busy_reg <= busy_next;
            o_ready  <= (busy_next < CW'(MEM_MODE)); // RULE_08
        end
    end

    // Direction is frozen per frame so a change mid-frame cannot mix transforms.
    always_ff @(posedge i_mclk) begin
        if (accept && in_cnt_reg == '0) begin
            inv_bank_reg[ld_b_reg] <= (i_inverse == RFFT_DIR_INV); // RULE_06
        end
    end

    // =====================================================================
    // Butterfly addressing and arithmetic
    always_comb begin
        int ql;
        int bfi;
        int ji;
        ql  = RFFT_RADIX_LOG * (NST - 1 - int'(stage_reg));
        bfi = int'(bf_reg);
        ji  = bfi & ((1 << ql) - 1);
        addr = LOGN'((((bfi >> ql) << (ql + RFFT_RADIX_LOG)) | ji) + (int'(k_reg) << ql)); // RULE_01
        tw_e = LOGN'((ji << (RFFT_RADIX_LOG * int'(stage_reg))) * int'(k_reg)); // RULE_02
    end

    always_comb begin
        rfft_wide_t t0r, t0i, t1r, t1i, t2r, t2i, t3r, t3i;
        rfft_wide_t w_re [4];
        rfft_wide_t w_im [4];
        int         sh;
        t0r = rfft_wide_t'(a_re[0]) + rfft_wide_t'(a_re[2]);
        t0i = rfft_wide_t'(a_im[0]) + rfft_wide_t'(a_im[2]);
        t1r = rfft_wide_t'(a_re[0]) - rfft_wide_t'(a_re[2]);
        t1i = rfft_wide_t'(a_im[0]) - rfft_wide_t'(a_im[2]);
        t2r = rfft_wide_t'(a_re[1]) + rfft_wide_t'(a_re[3]);
        t2i = rfft_wide_t'(a_im[1]) + rfft_wide_t'(a_im[3]);
        t3r = rfft_wide_t'(a_re[1]) - rfft_wide_t'(a_re[3]);
        t3i = rfft_wide_t'(a_im[1]) - rfft_wide_t'(a_im[3]);
        w_re[0] = t0r + t2r;
        w_im[0] = t0i + t2i;
        w_re[2] = t0r - t2r;
        w_im[2] = t0i - t2i;
        // Forward rotates the odd difference by -i, inverse by +i.
        w_re[1] = proc_inv ? t1r - t3i : t1r + t3i; // RULE_06
        w_im[1] = proc_inv ? t1i + t3r : t1i - t3r;
        w_re[3] = proc_inv ? t1r + t3i : t1r - t3i;
        w_im[3] = proc_inv ? t1i - t3r : t1i + t3r;
        // A quarter per stage gives 1/N; the extra halving on stage zero gives 1/(2N).
        sh = (stage_reg == '0 && HALF_SCALE) ? RFFT_RADIX_LOG + 1 : RFFT_RADIX_LOG; // RULE_11
        for (int i = 0; i < 4; i++) begin
            u_re[i] = rfft_smp_t'(w_re[i] >>> sh);
            u_im[i] = rfft_smp_t'(w_im[i] >>> sh);
        end
    end

    // The scaled sums always fit; only the twiddle product can exceed full scale.
    always_comb begin
        rfft_smp_t  c;
        rfft_smp_t  s;
        rfft_prod_t pr;
        rfft_prod_t pi;
        logic [RFFT_DATA_W:0] sr;
        logic [RFFT_DATA_W:0] si;
        c  = TW_COS[tw_e];
        s  = proc_inv ? -TW_SIN[tw_e] : TW_SIN[tw_e];
        pr = rfft_prod_t'(y_re[k_reg]) * rfft_prod_t'(c) + rfft_prod_t'(y_im[k_reg]) * rfft_prod_t'(s);
        pi = rfft_prod_t'(y_im[k_reg]) * rfft_prod_t'(c) - rfft_prod_t'(y_re[k_reg]) * rfft_prod_t'(s);
        pr = (pr + (rfft_prod_t'(1) <<< (RFFT_TW_FRAC - 1))) >>> RFFT_TW_FRAC;
        pi = (pi + (rfft_prod_t'(1) <<< (RFFT_TW_FRAC - 1))) >>> RFFT_TW_FRAC;
        sr = sat(pr);
        si = sat(pi);
        rot_re  = sr[RFFT_DATA_W-1:0];
        rot_im  = si[RFFT_DATA_W-1:0];
        rot_ovf = sr[RFFT_DATA_W] || si[RFFT_DATA_W];
    end

    // =====================================================================
    // Frame memories
    always_ff @(posedge i_mclk) begin
        if (accept) begin
            mem_re[ld_b_reg][in_cnt_reg] <= i_in_real; // RULE_04
            mem_im[ld_b_reg][in_cnt_reg] <= i_in_imag;
        end
        if (state_reg == st_wr) begin
            mem_re[pr_b_reg][addr] <= rot_re;
            mem_im[pr_b_reg][addr] <= rot_im;
        end
    end

    // =====================================================================
    // Transform sequencer
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin // RULE_16
            state_reg   <= st_idle;
            stage_reg   <= '0;
            bf_reg      <= '0;
            k_reg       <= '0;
            out_cnt_reg <= '0;
            ovf_reg     <= 1'b0;
        end else begin
            unique case (state_reg)
                st_idle: begin
                    if (busy_reg != '0) begin
                        state_reg <= st_rd;
                        stage_reg <= '0;
                        bf_reg    <= '0;
                        k_reg     <= '0;
                        ovf_reg   <= 1'b0;
                    end
                end
                st_rd: begin
                    a_re[k_reg] <= mem_re[pr_b_reg][addr]; // RULE_01
                    a_im[k_reg] <= mem_im[pr_b_reg][addr];
                    k_reg       <= k_reg + 1'b1;
                    if (k_reg == 2'b11) begin
                        state_reg <= st_calc;
                    end
                end
                st_calc: begin
                    y_re      <= u_re;
                    y_im      <= u_im;
                    state_reg <= st_wr;
                end
                st_wr: begin
                    ovf_reg <= ovf_reg || rot_ovf;
                    k_reg   <= k_reg + 1'b1;
                    if (k_reg == 2'b11) begin
                        state_reg <= st_rd;
                        bf_reg    <= bf_reg + 1'b1;
                        if (bf_reg == '1) begin
                            stage_reg <= stage_reg + 1'b1;
                            if (stage_reg == 3'(NST - 1)) begin
                                state_reg   <= st_out;
                                out_cnt_reg <= '0;
                            end
                        end
                    end
                end
                st_out: begin
                    if (out_adv) begin // RULE_18
                        out_cnt_reg <= out_cnt_reg + 1'b1;
                        if (out_cnt_reg == LAST_IDX) begin
                            state_reg <= st_idle;
                        end
                    end
                end
            endcase
        end
    end

    // =====================================================================
    // Output buffering and register
    rfft_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (RFFT_FIFO_DEPTH)
    ) u_fifo (
        .i_mclk     (i_mclk),
        .i_rst_n    (i_rst_n),
        .i_wr_valid ((state_reg == st_out) && !drop_frame), // RULE_12
        .o_wr_ready (fifo_wr_ready),
        .i_wr_data  ({ovf_reg, (out_cnt_reg == '0),
                      mem_re[pr_b_reg][digit_rev(out_cnt_reg)], mem_im[pr_b_reg][digit_rev(out_cnt_reg)]}),
        .o_rd_valid (fifo_rd_valid),
        .i_rd_ready (fifo_rd_ready),
        .o_rd_data  (fifo_rd_data)
    );

    assign fifo_rd_ready = !o_valid || i_out_ready;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin // RULE_17
            o_valid       <= 1'b0;
            o_bin_real    <= '0;
            o_bin_imag    <= '0;
            o_frame_start <= 1'b0;
            o_ovf         <= 1'b0;
        end else if (fifo_rd_ready) begin
            o_valid <= fifo_rd_valid;
            if (fifo_rd_valid) begin
                {o_ovf, o_frame_start, o_bin_real, o_bin_imag} <= fifo_rd_data; // RULE_05 RULE_07 RULE_19
            end
        end
    end

    // Index of the bin on the output port, kept only for checking.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            out_idx_reg <= '0;
        end else if (o_valid && i_out_ready) begin
            out_idx_reg <= (out_idx_reg == LAST_IDX) ? '0 : out_idx_reg + 1'b1;
        end
    end

    // =====================================================================
    // Assertions
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    a_ready_room:  assert property ($past(i_rst_n) |-> o_ready == (busy_reg < CW'(MEM_MODE))) // RULE_08
        else $error("ready does not match free frame memory");
    a_drop_stall:  assert property ((i_in_valid && !o_ready) |=> $stable(in_cnt_reg)) // RULE_14
        else $error("sample taken while not ready");
    a_frame_wrap:  assert property (load_done |=> in_cnt_reg == '0 && busy_reg != '0) // RULE_03
        else $error("input frame did not close after N samples");
    a_bfly_reads:  assert property (state_reg == st_calc |-> $past(state_reg, 4) == st_rd
                                    && $past(state_reg) == st_rd) // RULE_01
        else $error("butterfly did not read four points");
    a_last_stage:  assert property ($rose(state_reg == st_out) |-> $past(stage_reg) == 3'(NST - 1)) // RULE_01
        else $error("output began before the last stage");
    a_tw_unity:    assert property ((state_reg == st_wr && k_reg == '0) |->
                                    rot_re == y_re[0] && rot_im == y_im[0] && !rot_ovf) // RULE_02
        else $error("zero twiddle exponent changed the sum output");
    a_start_first: assert property (o_valid |-> o_frame_start == (out_idx_reg == '0)) // RULE_07
        else $error("frame start not on first bin");
    a_inval_drop:  assert property (o_valid |-> !(o_ovf && INVALIDATE)) // RULE_12
        else $error("overflowed frame delivered although invalidated");
    a_out_hold:    assert property ((o_valid && !i_out_ready) |=> o_valid && $stable(o_bin_real)
                                    && $stable(o_bin_imag)) // RULE_05
        else $error("output bin changed while stalled");
    a_reset_clear: assert property (@(posedge i_mclk) disable iff (1'b0)
                                    !i_rst_n |=> !o_valid && !o_ready && busy_reg == '0
                                    && state_reg == st_idle) // RULE_16
        else $error("reset did not return to idle");

    c_frame_in:  cover property (load_done);
    c_frame_out: cover property (o_valid && o_frame_start && i_out_ready);
    c_overflow:  cover property (state_reg == st_wr && rot_ovf);
    c_stalled:   cover property (state_reg == st_out && !fifo_wr_ready);
endmodule

/* verification/rfft_partner.sv */
// Far-side model: a tone sample source and a bin consumer that stalls.
// Assumes samples are taken at a rising edge with valid and ready high.

// ============================================================
// Partner model
module rfft_partner
    import rfft_pkg::*;
#(
    parameter int                     N   = 16,
    parameter logic [RFFT_DATA_W-1:0] AMP = 16'h0400
) (
    // Clock, reset and enable
    input  wire logic                   i_mclk,
    input  wire logic                   i_rst_n,
    input  wire logic                   i_en,
    // Unit side
    input  wire logic                   i_dut_ready,
    output logic                        o_in_valid,
    output logic [RFFT_DATA_W-1:0]      o_in_real,
    output logic [RFFT_DATA_W-1:0]      o_in_imag,
    output logic                        o_inverse,
    output logic                        o_out_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0]            taken = 16'h0000;
    logic [1:0]             cyc   = 2'h0;
    logic                   live  = 1'b0;
    logic                   stall = 1'b1;
    logic                   inv   = 1'b0;
    logic [RFFT_DATA_W-1:0] re    = 16'h0000;
    logic [RFFT_DATA_W-1:0] im    = 16'h0000;
    assign o_in_valid  = live;
    assign o_in_real   = re;
    assign o_in_imag   = im;
    assign o_inverse   = inv;
    assign o_out_ready = ~stall;
    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            taken <= 16'h0000;
        end else if (live && i_dut_ready) begin
            taken <= taken + 16'h0001;
        end
        cyc <= (cyc == 2'h2) ? 2'h0 : cyc + 2'h1;
    end
    // Sample m is AMP times i to the power m, a tone on bin N/4.
    always @(negedge i_mclk) begin
        live  <= i_en;
        stall <= (cyc == 2'h2);
        inv   <= taken[$clog2(N)];
        if (i_dut_ready) begin
            re <= taken[0] ? 16'h0000 : (taken[1] ? -AMP : AMP);
            im <= taken[0] ? (taken[1] ? -AMP : AMP) : 16'h0000;
        end else begin
            re <= ~re;
            im <= ~im;
        end
    end
endmodule

/* verification/streaming_radix4_fft_test.sv */
// Bench of the transform: tone frames both ways, output stalls, reset mid-frame.
// Assumes the partner model drives every sample and consumer input.

// ============================================================
// Bench
module streaming_radix4_fft_test;
    timeunit 1ns;
    timeprecision 100ps;
    import rfft_pkg::*;
    localparam int          N   = 16;
    localparam logic [15:0] AMP = 16'h0400;
    logic                   i_mclk     = 1'b0;
    logic                   i_rst_n    = 1'b0;
    logic                   en         = 1'b0;
    logic                   in_valid, inverse, ready, valid, out_ready, fstart, ovf;
    logic [RFFT_DATA_W-1:0] in_real, in_imag, bin_real, bin_imag;
    int                     n_mismatch = 0;
    int                     checked    = 0;
    int                     cycles     = 0;
    int                     w;
    always #2 i_mclk = ~i_mclk;
    rfft_stream #(.N_POINTS(N), .MEM_MODE(RFFT_MEM_SINGLE)) uut (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_in_valid(in_valid), .i_in_real(in_real),
        .i_in_imag(in_imag), .i_inverse(inverse), .o_ready(ready), .o_valid(valid),
        .i_out_ready(out_ready), .o_bin_real(bin_real), .o_bin_imag(bin_imag),
        .o_frame_start(fstart), .o_ovf(ovf));
    rfft_partner #(.N(N), .AMP(AMP)) model (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_en(en), .i_dut_ready(ready), .o_in_valid(in_valid),
        .o_in_real(in_real), .o_in_imag(in_imag), .o_inverse(inverse), .o_out_ready(out_ready));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Bins are looked at after the falling edge, so stalls and updates have settled.
    task automatic read_frame(input logic inv);
        int k;
        int t;
        k = 0;
        t = 0;
        while (k < N && t < 2000) begin
            @(negedge i_mclk);
            #1;
            t++;
            if (valid === 1'b1 && out_ready === 1'b1) begin
                check(bin_real, (k == (inv ? 3 * N / 4 : N / 4)) ? AMP : 16'h0000);
                check(bin_imag, 16'h0000);
                check({15'h0000, fstart}, {15'h0000, k == 0});
                check({15'h0000, ovf}, 16'h0000);
                k++;
                t = 0;
            end
        end
        check(16'(k), 16'(N));
    endtask
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        repeat (8) @(negedge i_mclk);
        check({15'h0000, ready}, 16'h0000);
        check({15'h0000, valid}, 16'h0000);
        i_rst_n = 1'b1;
        repeat (2) @(negedge i_mclk);
        check({15'h0000, ready}, 16'h0001);
        repeat (3) @(negedge i_mclk);
        en = 1'b1;
        read_frame(1'b0);
        read_frame(1'b1);
        read_frame(1'b0);
        // Wait for the first bin of the fourth frame, so the reset lands on an output frame in progress.
        w = 0;
        while (!(valid === 1'b1 && fstart === 1'b1) && w < 2000) begin
            @(negedge i_mclk);
            w++;
        end
        check({15'h0000, fstart}, 16'h0001);
        i_rst_n = 1'b0;
        @(negedge i_mclk);
        check({15'h0000, valid}, 16'h0000);
        check({15'h0000, ready}, 16'h0000);
        check({15'h0000, fstart}, 16'h0000);
        i_rst_n = 1'b1;
        read_frame(1'b0);
        results();
    end
endmodule
